// ==== rtl/i2cs_map.svh ====
/*
  Register offsets, field positions, reset values and timing counts
  for the buffered two-wire slave. Assumes a 125 MHz system clock.
*/
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH

// register word offsets on the cpu port
`define REG_CFG    3'h0
`define REG_SADDR  3'h1
`define REG_STAT   3'h2
`define REG_CTRL   3'h3
`define REG_DATA   3'h4
`define REG_BPTR   3'h5
`define REG_BDATA  3'h6

// configuration fields
`define CFG_EN     0
`define CFG_BUF    1
`define CFG_MON    2
`define CFG_ANY    3
`define CFG_IRQ    4

// status fields
`define ST_DONE    0
`define ST_ADDR    1
`define ST_TX      2
`define ST_NACK    3
`define ST_START   4
`define ST_STOP    5
`define ST_BUSY    6
`define ST_FAST    7

// control fields
`define CTRL_REL   0

// reset values
`define CFG_RST    5'h00
`define SADDR_RST  7'h08
`define DATA_RST   8'h00

// timing: fastest legal serial clock period, rounded down to cycles
`define CLK_NS        8
`define SCL_PERIOD_NS 2500
`define SCL_MIN_CYC   (`SCL_PERIOD_NS / `CLK_NS)

`endif

// ==== rtl/i2cs_pkg.sv ====
/*
  Types shared by the buffered two-wire slave.
  Assumes the map header supplies all numeric constants.
*/
package i2cs_pkg;

  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK,
    ST_TX, ST_TACK, ST_STALL, ST_IGNORE
  } i2cs_state_e;

  // configuration bits as one carrier
  typedef struct packed {
    logic irq_en;
    logic any;
    logic mon;
    logic buf_mode;
    logic en;
  } i2cs_cfg_s;

  // line event pulses from the edge detector
  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } i2cs_ev_s;

endpackage : i2cs_pkg

// ==== rtl/i2cs_sync.sv ====
/*
  Two-flop synchroniser, one per input bit.
  Assumes asynchronous inputs and one system clock.
*/
`timescale 1ns/1ns
module i2cs_sync #(
  parameter int WIDTH = 2
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // lines idle high, so reset to released level
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        meta_reg[i] <= 1'b1;
        sync_reg[i] <= 1'b1;
      end
      else
      begin
        meta_reg[i] <= d[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  assign q = sync_reg;

endmodule : i2cs_sync

// ==== rtl/i2cs_top.sv ====
/*
  Buffered two-wire bus slave: byte engine, address compare, stall or
  32-byte ram buffer mode, bus monitor mode, cpu register port.
  Assumes pins are open drain (oe high pulls low) and the cpu port
  follows the one-cycle strobe protocol on the same clock.
*/
`timescale 1ns/1ns
`include "i2cs_map.svh"
module i2cs_top
  import i2cs_pkg::*;
#(
  parameter int DEPTH = 32
)(
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire logic       SCL_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE,
  output logic            PIN_EN,
  output logic            IRQ
);

  localparam int PW = $clog2(DEPTH);

  logic [1:0]    pin_s;
  logic          scl_d_reg;
  logic          sda_d_reg;
  i2cs_ev_s      ev;
  i2cs_cfg_s     cfg_reg;
  logic [6:0]    saddr_reg;
  logic [7:0]    tx_data_reg;
  logic [7:0]    rx_data_reg;
  logic [PW-1:0] bptr_reg;
  logic [7:0]    ram [DEPTH];
  i2cs_state_e   state_reg;
  logic [3:0]    cnt_reg;
  logic [7:0]    shift_reg;
  logic          rw_reg;
  logic          first_reg;
  logic [PW-1:0] ptr_reg;
  logic          sda_oe_reg;
  logic          scl_oe_reg;
  logic          done_reg;
  logic          aflag_reg;
  logic          dir_reg;
  logic          nack_reg;
  logic          sta_reg;
  logic          sto_reg;
  logic          busy_reg;
  logic          fast_reg;
  logic [8:0]    per_reg;
  logic [7:0]    rdata_reg;
  logic          pin_en_reg;
  logic          irq_reg;
  logic          match;
  logic          rel;
  logic          stat_wr;
  logic          ram_bus_we;
  logic [7:0]    tx_src;

  // pins pass two flops before anything looks at them
  i2cs_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk (CLOCK),
    .rst (RESET),
    .d   ({SCL_IN, SDA_IN}),
    .q   (pin_s)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= pin_s[1];
      sda_d_reg <= pin_s[0];
    end
  end

  // start and stop are sda edges while scl stays high
  assign ev.rise  = pin_s[1] & ~scl_d_reg;
  assign ev.fall  = ~pin_s[1] & scl_d_reg;
  assign ev.start = pin_s[1] & scl_d_reg & sda_d_reg & ~pin_s[0];
  assign ev.stop  = pin_s[1] & scl_d_reg & ~sda_d_reg & pin_s[0];

  // address compare; the any bit hands 10-bit and smbus to firmware
  assign match = cfg_reg.any | (shift_reg[7:1] == saddr_reg);

  assign rel     = WR && (ADDR == `REG_CTRL) && WDATA[`CTRL_REL];
  assign stat_wr = WR && (ADDR == `REG_STAT);

  // buffer write slot: second and later bytes of a master write
  assign ram_bus_we = cfg_reg.en && !cfg_reg.mon && cfg_reg.buf_mode
                    && state_reg == ST_RX && ev.fall && cnt_reg == 4'h8
                    && !first_reg && !ev.stop && !ev.start;

  // next byte to send: ram in buffered mode, cpu byte otherwise
  assign tx_src = cfg_reg.buf_mode ? ram[ptr_reg] : tx_data_reg;

  // cpu-written configuration
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      cfg_reg     <= `CFG_RST;
      saddr_reg   <= `SADDR_RST;
      tx_data_reg <= `DATA_RST;
      bptr_reg    <= '0;
    end
    else if (WR)
    begin
      case (ADDR)
        `REG_CFG:   cfg_reg     <= WDATA[4:0];
        `REG_SADDR: saddr_reg   <= WDATA[6:0];
        `REG_DATA:  tx_data_reg <= WDATA;
        `REG_BPTR:  bptr_reg    <= WDATA[PW-1:0];
        default:    ;
      endcase
    end
  end

  // buffer ram; the bus side wins a same-cycle collision
  always_ff @(posedge CLOCK)
  begin
    if (ram_bus_we)
      ram[ptr_reg] <= shift_reg;
    else if (WR && ADDR == `REG_BDATA)
      ram[bptr_reg] <= WDATA;
  end

  // serial byte engine, slave only
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      rw_reg      <= 1'b0;
      first_reg   <= 1'b0;
      ptr_reg     <= '0;
      sda_oe_reg  <= 1'b0;
      scl_oe_reg  <= 1'b0;
      rx_data_reg <= 8'h00;
      done_reg    <= 1'b0;
      aflag_reg   <= 1'b0;
      dir_reg     <= 1'b0;
      nack_reg    <= 1'b0;
    end
    else
    begin
      if (stat_wr && WDATA[`ST_NACK])
        nack_reg <= 1'b0;
      // disabled or monitoring: never touch the lines
      if (!cfg_reg.en || cfg_reg.mon || ev.stop)
      begin
        state_reg  <= ST_IDLE;
        sda_oe_reg <= 1'b0;
        scl_oe_reg <= 1'b0;
        cnt_reg    <= 4'h0;
      end
      else if (ev.start)
      begin
        state_reg  <= ST_ADDR;
        cnt_reg    <= 4'h0;
        sda_oe_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_RX:
          begin
            // bits are taken on the rising clock
            if (ev.rise && cnt_reg != 4'h8)
            begin
              shift_reg <= {shift_reg[6:0], pin_s[0]};
              cnt_reg   <= cnt_reg + 4'h1;
            end
            else if (ev.fall && cnt_reg == 4'h8)
            begin
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR)
              begin
                if (match)
                begin
                  sda_oe_reg <= 1'b1;
                  rw_reg     <= shift_reg[0];
                  first_reg  <= 1'b1;
                  state_reg  <= ST_AACK;
                end
                else
                  state_reg <= ST_IGNORE;
              end
              else
              begin
                sda_oe_reg  <= 1'b1;
                rx_data_reg <= shift_reg;
                state_reg   <= ST_RACK;
                if (cfg_reg.buf_mode && first_reg)
                begin
                  ptr_reg   <= shift_reg[PW-1:0];
                  first_reg <= 1'b0;
                end
                else if (cfg_reg.buf_mode)
                  ptr_reg <= ptr_reg + 1'b1;
              end
            end
          end
          ST_AACK:
          begin
            if (ev.fall)
            begin
              sda_oe_reg <= 1'b0;
              aflag_reg  <= 1'b1;
              dir_reg    <= rw_reg;
              if (!cfg_reg.buf_mode)
              begin
                scl_oe_reg <= 1'b1;
                done_reg   <= 1'b1;
                state_reg  <= ST_STALL;
              end
              else if (rw_reg)
              begin
                shift_reg  <= tx_src;
                sda_oe_reg <= ~tx_src[7];
                ptr_reg    <= ptr_reg + 1'b1;
                state_reg  <= ST_TX;
              end
              else
                state_reg <= ST_RX;
            end
          end
          ST_RACK:
          begin
            if (ev.fall)
            begin
              sda_oe_reg <= 1'b0;
              if (!cfg_reg.buf_mode)
              begin
                aflag_reg  <= 1'b0;
                scl_oe_reg <= 1'b1;
                done_reg   <= 1'b1;
                state_reg  <= ST_STALL;
              end
              else
                state_reg <= ST_RX;
            end
          end
          ST_TX:
          begin
            // data changes only while scl is low
            if (ev.fall)
            begin
              if (cnt_reg == 4'h7)
              begin
                sda_oe_reg <= 1'b0;
                cnt_reg    <= 4'h0;
                state_reg  <= ST_TACK;
              end
              else
              begin
                cnt_reg    <= cnt_reg + 4'h1;
                shift_reg  <= {shift_reg[6:0], 1'b0};
                sda_oe_reg <= ~shift_reg[6];
              end
            end
          end
          ST_TACK:
          begin
            // master ack sampled on rise, next byte after fall
            if (ev.rise && pin_s[0])
            begin
              nack_reg  <= 1'b1;
              state_reg <= ST_IGNORE;
            end
            else if (ev.rise)
              cnt_reg <= 4'h1;
            else if (ev.fall && cnt_reg == 4'h1)
            begin
              cnt_reg <= 4'h0;
              if (!cfg_reg.buf_mode)
              begin
                aflag_reg  <= 1'b0;
                scl_oe_reg <= 1'b1;
                done_reg   <= 1'b1;
                state_reg  <= ST_STALL;
              end
              else
              begin
                shift_reg  <= tx_src;
                sda_oe_reg <= ~tx_src[7];
                ptr_reg    <= ptr_reg + 1'b1;
                state_reg  <= ST_TX;
              end
            end
          end
          ST_STALL:
          begin
            // switching to buffered mode also lets the clock go
            if (rel || cfg_reg.buf_mode)
            begin
              done_reg   <= 1'b0;
              scl_oe_reg <= 1'b0;
              if (rw_reg)
              begin
                shift_reg  <= tx_src;
                sda_oe_reg <= ~tx_src[7];
                if (cfg_reg.buf_mode)
                  ptr_reg <= ptr_reg + 1'b1;
                state_reg <= ST_TX;
              end
              else
                state_reg <= ST_RX;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sticky bus-condition flags; set wins over a cpu clear
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      sta_reg  <= 1'b0;
      sto_reg  <= 1'b0;
      busy_reg <= 1'b0;
      fast_reg <= 1'b0;
      per_reg  <= 9'h000;
    end
    else
    begin
      if (stat_wr && WDATA[`ST_START])
        sta_reg <= 1'b0;
      if (stat_wr && WDATA[`ST_STOP])
        sto_reg <= 1'b0;
      if (stat_wr && WDATA[`ST_FAST])
        fast_reg <= 1'b0;
      if (ev.start)
      begin
        sta_reg  <= 1'b1;
        busy_reg <= 1'b1;
      end
      if (ev.stop)
      begin
        sto_reg  <= 1'b1;
        busy_reg <= 1'b0;
      end
      // flag a master clocking faster than the supported rate
      if (ev.rise)
      begin
        if (busy_reg && per_reg < 9'(`SCL_MIN_CYC))
          fast_reg <= 1'b1;
        per_reg <= 9'h000;
      end
      else if (per_reg != 9'h1FF)
        per_reg <= per_reg + 9'h001;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
      rdata_reg <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `REG_CFG:   rdata_reg <= {3'h0, cfg_reg};
        `REG_SADDR: rdata_reg <= {1'b0, saddr_reg};
        `REG_STAT:  rdata_reg <= {fast_reg, busy_reg, sto_reg, sta_reg,
                                  nack_reg, dir_reg, aflag_reg, done_reg};
        `REG_DATA:  rdata_reg <= rx_data_reg;
        `REG_BPTR:  rdata_reg <= 8'(bptr_reg);
        `REG_BDATA: rdata_reg <= ram[bptr_reg];
        default:    rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  // pin claim and interrupt request, both registered
  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      pin_en_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      pin_en_reg <= cfg_reg.en;
      irq_reg    <= cfg_reg.irq_en & (done_reg | sto_reg | nack_reg);
    end
  end

  assign RDATA   = rdata_reg;
  assign SDA_OE  = sda_oe_reg;
  assign SCL_OE  = scl_oe_reg;
  assign SDA_OUT = 1'b0; // open drain: only ever pulls low
  assign SCL_OUT = 1'b0;
  assign PIN_EN  = pin_en_reg;
  assign IRQ     = irq_reg;

  // checks on the engine and register port
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  chk_buf_no_stretch: assert property (
    cfg_reg.buf_mode && scl_oe_reg |=> !scl_oe_reg)
    else $error("clock held low in buffered mode");
  chk_stall_only_default: assert property (
    $rose(scl_oe_reg) |-> !$past(cfg_reg.buf_mode))
    else $error("stall began in buffered mode");
  chk_stall_release: assert property (
    state_reg == ST_STALL && rel && !ev.stop |=> !scl_oe_reg && state_reg != ST_STALL)
    else $error("release did not free the clock");
  chk_stall_holds: assert property (
    state_reg == ST_STALL |-> scl_oe_reg && done_reg)
    else $error("stall without clock hold");
  chk_addr_miss: assert property (
    state_reg == ST_ADDR && ev.fall && cnt_reg == 4'h8 && !match
      && cfg_reg.en && !cfg_reg.mon && !ev.stop && !ev.start
    |=> state_reg == ST_IGNORE && !sda_oe_reg)
    else $error("unmatched address acknowledged");
  chk_monitor_quiet: assert property (
    $past(cfg_reg.mon) && cfg_reg.mon |-> !sda_oe_reg && !scl_oe_reg)
    else $error("monitor mode drove a line");
  chk_stop_idle: assert property (
    ev.stop |=> state_reg == ST_IDLE ##0 !sda_oe_reg ##0 !scl_oe_reg)
    else $error("stop did not idle the engine");
  chk_read_slot: assert property (
    !$past(RD) |-> rdata_reg == 8'h00)
    else $error("read data outside its slot");
  chk_ptr_load: assert property (
    cfg_reg.buf_mode && state_reg == ST_RX && ev.fall && cnt_reg == 4'h8
      && first_reg && cfg_reg.en && !cfg_reg.mon && !ev.stop && !ev.start
    |=> ptr_reg == $past(shift_reg[PW-1:0]) && !first_reg)
    else $error("first byte did not load pointer");
  chk_pin_claim: assert property (
    pin_en_reg == $past(cfg_reg.en))
    else $error("pin claim lags enable");
  chk_done_rise: assert property (
    $rose(done_reg) |-> state_reg == ST_STALL)
    else $error("byte flag without stall");

  cov_stall: cover property (state_reg == ST_STALL ##1 rel);
  cov_buf_write: cover property (ram_bus_we);
  cov_tx_nack: cover property (state_reg == ST_TACK ##1 nack_reg);

endmodule : i2cs_top

// ==== tb/i2cs_master_model.sv ====
/*
  Behavioural two-wire bus master that drives the slave's pins.
  Assumes open-drain wires with pull-ups built in the testbench.
*/
`timescale 1ns/1ns
module i2cs_master_model #(
  parameter int QTR = 80
)(
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      fault
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    fault   = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap

  // a stalled clock must be let go by the slave; a bound stops a hang
  task automatic wait_high();
    int n;
    n = 0;
    while (scl !== 1'b1 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) fault <= 1'b1;
  endtask : wait_high

  // four quarters of 80 cycles plus the wait cycle keep the period at 2568 ns or more, not under 2500
  task automatic bit_xfer(input logic v, output logic s);
    gap(QTR);
    sda_low <= !v;
    gap(QTR);
    scl_low <= 1'b0;
    wait_high();
    gap(QTR);
    s = sda;
    gap(QTR);
    scl_low <= 1'b1;
  endtask : bit_xfer

  // serves as first and repeated start alike; the leading quarter keeps
  // rise-to-rise at a full bit period after a data bit
  task automatic start_cond();
    gap(QTR);
    sda_low <= 1'b0;
    gap(QTR);
    scl_low <= 1'b0;
    wait_high();
    gap(QTR);
    sda_low <= 1'b1;
    gap(QTR);
    scl_low <= 1'b1;
  endtask : start_cond

  task automatic stop_cond();
    gap(QTR);
    sda_low <= 1'b1;
    gap(QTR);
    scl_low <= 1'b0;
    wait_high();
    gap(QTR);
    sda_low <= 1'b0;
    gap(2 * QTR);
  endtask : stop_cond

  // msb first, then the ack slot with the data line released
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], s);
    bit_xfer(1'b1, ack);
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(nack, s);
  endtask : rd_byte
endmodule : i2cs_master_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the buffered two-wire slave.
  Assumes the master model on the pins and the one-cycle cpu port.
*/
`timescale 1ns/1ns
`include "i2cs_map.svh"
module testbench;
  typedef struct packed {
    logic [7:0] exp;
    logic [7:0] mask;
    logic       chk;
  } i2cs_note_s;

  logic       CLOCK = 1'b0;
  logic       RESET = 1'b1;
  logic [2:0] ADDR  = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR    = 1'b0;
  logic       RD    = 1'b0;
  logic [7:0] RDATA;
  logic       SDA_OUT, SDA_OE, SCL_OUT, SCL_OE, PIN_EN, IRQ;
  logic       m_scl, m_sda, m_fault, ack, rd_d = 1'b0;
  wire        scl_w, sda_w;
  int         errors = 0;
  int         comparisons = 0;
  int         oe_cyc = 0;
  int         base;
  integer     seed = 32'h9dbf_7cb8;
  logic [6:0] sa;
  logic [7:0] d, e, a, b, got;
  i2cs_note_s notes[$];

  always #4 CLOCK = ~CLOCK;
  // pull-ups: a line is low only while some party pulls it
  assign scl_w = !(m_scl | (SCL_OE & !SCL_OUT));
  assign sda_w = !(m_sda | (SDA_OE & !SDA_OUT));

  i2cs_top u_i2cs_top (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .PIN_EN(PIN_EN), .IRQ(IRQ));
  i2cs_master_model u_i2cs_master_model (.clk(CLOCK), .scl(scl_w), .sda(sda_w),
    .scl_low(m_scl), .sda_low(m_sda), .fault(m_fault));

  task automatic report_and_stop();
    $display("counts: comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // x in a watched bit never matches
  task automatic check8(input logic [7:0] g, input logic [7:0] x, input logic [7:0] m);
    comparisons++;
    if (((g ^ x) & m) !== 8'h00)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask : check8

  task automatic reg_wr(input logic [2:0] ad, input logic [7:0] wd);
    @(posedge CLOCK);
    ADDR  <= ad;
    WDATA <= wd;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask : reg_wr

  // a note with an empty mask is a poll and is not compared
  task automatic reg_rd(input logic [2:0] ad, input logic [7:0] x, input logic [7:0] m,
                        output logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= ad;
    RD   <= 1'b1;
    notes.push_back('{x, m, m != 8'h00});
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1 v = RDATA;
  endtask : reg_rd

  task automatic reg_chk(input logic [2:0] ad, input logic [7:0] x, input logic [7:0] m);
    logic [7:0] v;
    reg_rd(ad, x, m, v);
  endtask : reg_chk

  // poll the done flag under a bound
  task automatic wait_done();
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h00;
    while (v[`ST_DONE] !== 1'b1 && n < 200)
    begin
      reg_rd(`REG_STAT, 8'h00, 8'h00, v);
      n++;
    end
    if (n >= 200)
    begin
      errors++;
      report_and_stop();
    end
  endtask : wait_done

  task automatic m_wr(input logic [7:0] bt, input logic x);
    u_i2cs_master_model.wr_byte(bt, ack);
    check8({7'h00, ack}, {7'h00, x}, 8'h01);
  endtask : m_wr

  // read data stand only in the cycle after the strobe
  always @(posedge CLOCK)
  begin : watch
    i2cs_note_s nt;
    if (rd_d && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt.chk) check8(RDATA, nt.exp, nt.mask);
    end
    rd_d <= RD;
    if (SCL_OE === 1'b1) oe_cyc <= oe_cyc + 1;
  end

  always @(posedge m_fault)
  begin
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (100000) @(posedge CLOCK);
    errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    reg_chk(`REG_CFG, 8'h00, 8'h1f);
    reg_chk(`REG_SADDR, 8'h08, 8'h7f);
    reg_chk(`REG_CTRL, 8'h00, 8'hff);
    check8({7'h00, PIN_EN}, 8'h00, 8'h01);
    sa = 7'($random(seed));
    reg_wr(`REG_SADDR, {1'b0, sa});
    reg_wr(3'h7, 8'($random(seed)));
    reg_chk(`REG_SADDR, {1'b0, sa}, 8'h7f);
    reg_chk(3'h7, 8'h00, 8'hff);
    $display("test registers finished");
    // default mode write with interrupt enabled
    reg_wr(`REG_CFG, 8'h11);
    @(posedge CLOCK);
    #1 check8({7'h00, PIN_EN}, 8'h01, 8'h01);
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b0}, 1'b0);
    wait_done();
    reg_chk(`REG_STAT, 8'h53, 8'hff);
    check8({7'h00, SCL_OE}, 8'h01, 8'h01);
    check8({7'h00, IRQ}, 8'h01, 8'h01);
    reg_wr(`REG_CTRL, 8'h01);
    d = 8'($random(seed));
    m_wr(d, 1'b0);
    wait_done();
    reg_chk(`REG_STAT, 8'h51, 8'hff);
    reg_chk(`REG_DATA, d, 8'hff);
    reg_wr(`REG_CTRL, 8'h01);
    u_i2cs_master_model.stop_cond();
    reg_chk(`REG_STAT, 8'h30, 8'hff);
    check8({7'h00, IRQ}, 8'h01, 8'h01);
    reg_wr(`REG_STAT, 8'hff);
    reg_chk(`REG_STAT, 8'h00, 8'hff);
    check8({7'h00, IRQ}, 8'h00, 8'h01);
    $display("test default write finished");
    // another address is ignored and never stalls
    base = oe_cyc;
    u_i2cs_master_model.start_cond();
    m_wr({sa ^ 7'h01, 1'b0}, 1'b1);
    u_i2cs_master_model.stop_cond();
    check8({7'h00, oe_cyc != base}, 8'h00, 8'hff);
    reg_wr(`REG_STAT, 8'hff);
    $display("test address mismatch finished");
    // default mode read, master ends with nack
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b1}, 1'b0);
    wait_done();
    reg_chk(`REG_STAT, 8'h57, 8'hff);
    d = 8'($random(seed));
    reg_wr(`REG_DATA, d);
    reg_wr(`REG_CTRL, 8'h01);
    u_i2cs_master_model.rd_byte(1'b1, got);
    check8(got, d, 8'hff);
    u_i2cs_master_model.stop_cond();
    reg_chk(`REG_STAT, 8'h08, 8'h08);
    reg_wr(`REG_STAT, 8'hff);
    $display("test default read finished");
    // buffered mode: pointer load, consecutive access, wrap at 32
    reg_wr(`REG_CFG, 8'h03);
    base = oe_cyc;
    e = 8'($random(seed));
    a = 8'($random(seed));
    b = 8'($random(seed));
    reg_wr(`REG_BPTR, 8'h00);
    reg_wr(`REG_BDATA, e);
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b0}, 1'b0);
    m_wr(8'h1e, 1'b0);
    m_wr(a, 1'b0);
    m_wr(b, 1'b0);
    u_i2cs_master_model.stop_cond();
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b0}, 1'b0);
    m_wr(8'h1f, 1'b0);
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b1}, 1'b0);
    u_i2cs_master_model.rd_byte(1'b0, got);
    check8(got, b, 8'hff);
    u_i2cs_master_model.rd_byte(1'b1, got);
    check8(got, e, 8'hff);
    u_i2cs_master_model.stop_cond();
    reg_wr(`REG_BPTR, 8'h1e);
    reg_chk(`REG_BPTR, 8'h1e, 8'hff);
    reg_chk(`REG_BDATA, a, 8'hff);
    check8({7'h00, oe_cyc != base}, 8'h00, 8'hff);
    $display("test buffered mode finished");
    // monitor mode sees the bus but never answers
    reg_wr(`REG_CFG, 8'h05);
    reg_wr(`REG_STAT, 8'hff);
    u_i2cs_master_model.start_cond();
    m_wr({sa, 1'b0}, 1'b1);
    u_i2cs_master_model.stop_cond();
    reg_chk(`REG_STAT, 8'h30, 8'h30);
    $display("test monitor mode finished");
    report_and_stop();
  end
endmodule : testbench
